// >>> pkg/ldr_pkg.sv
package ldr_pkg;
  localparam int NUM_STAGES = 18;
  localparam int NUM_DIAG_REGS = 5;
  localparam int STAGES_PER_REG = 4;

  // Read selects of the read commands, one per register
  localparam logic [2:0] SEL_DIAG_1_4 = 3'h0;
  localparam logic [2:0] SEL_DIAG_5_8 = 3'h1;
  localparam logic [2:0] SEL_DIAG_9_12 = 3'h2;
  localparam logic [2:0] SEL_DIAG_13_16 = 3'h3;
  localparam logic [2:0] SEL_DIAG_17_18_BATT = 3'h4;
  localparam logic [2:0] SEL_CONFIG = 3'h5;

  localparam logic [7:0] DIAG_RESET = 8'hFF;
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  // Fifth diagnostic register layout
  localparam int BATT_FLAG_BIT = 4;
  localparam logic [2:0] DIAG5_UNUSED_VAL = 3'h7;

  // Configuration register layout
  localparam int CFG_FIXED_BIT = 0;
  localparam int CFG_SRC_SEL_BIT = 1;
  localparam int CFG_S17_BIT = 2;
  localparam int CFG_S18_BIT = 3;
  localparam int CFG_S9_BIT = 4;
  localparam int CFG_S10_BIT = 5;
  localparam int CFG_S15_BIT = 6;
  localparam int CFG_S16_BIT = 7;

  typedef enum logic [1:0] {
    FC_SHORT_GND = 2'h0,
    FC_OPEN_LOAD = 2'h1,
    FC_SHORT_BATT_OT = 2'h2,
    FC_NO_FAULT = 2'h3
  } ldr_fault_code_t;
endpackage

// >>> test/ldr_host_model.sv
`timescale 1ns/100ps
// Host command source; every strobe lasts exactly one clock
module ldr_host_model (
  input wire logic clk_i, // Clock
  output logic rd_req_o, // Read strobe
  output logic [2:0] rd_sel_o, // Read select
  output logic wr_cfg_o, // Config write strobe
  output logic [7:0] wr_data_o, // Write data
  output logic clr_o // Clear-faults strobe
);
  initial begin
    rd_req_o = 1'b0;
    rd_sel_o = 3'h0;
    wr_cfg_o = 1'b0;
    wr_data_o = 8'h00;
    clr_o = 1'b0;
  end
  // Kind 0 read, 1 config write, 2 clear; returns at the taking edge
  task automatic cmd(input logic [1:0] kind, input logic [7:0] v);
    @(posedge clk_i);
    rd_req_o <= (kind == 2'h0);
    wr_cfg_o <= (kind == 2'h1);
    clr_o <= (kind == 2'h2);
    rd_sel_o <= v[2:0];
    wr_data_o <= v;
    @(posedge clk_i);
    rd_req_o <= 1'b0;
    wr_cfg_o <= 1'b0;
    clr_o <= 1'b0;
    // Released data must not look like the last value
    wr_data_o <= ~v;
  endtask
endmodule // ldr_host_model

// >>> test/ldr_regs_bench.sv
`timescale 1ns/100ps
module ldr_regs_bench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce = 1'b1;
  logic [35:0] faults = {36{1'b1}};
  logic batt = 1'b0;
  logic vdd = 1'b1;
  logic rd_req, wr_cfg, clr, rd_valid, src_sel, bvalid;
  logic [2:0] rd_sel;
  logic [7:0] wr_data, rd_data;
  logic [17:0] shutoff, restart, mask, es;
  int err_total = 0;
  int checks_done = 0;
  int code[18];
  int cfg;
  always #12.5 clk_i = ~clk_i;
  ldr_host_model i_ldr_host_model (.clk_i(clk_i), .rd_req_o(rd_req), .rd_sel_o(rd_sel),
    .wr_cfg_o(wr_cfg), .wr_data_o(wr_data), .clr_o(clr));
  ldr_regs i_ldr_regs (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .rd_req_i(rd_req),
    .rd_sel_i(rd_sel), .wr_cfg_i(wr_cfg), .wr_data_i(wr_data), .clear_faults_cmd_i(clr),
    .fault_code_bits_i(faults), .battery_sense_i(batt), .vdd_ok_i(vdd),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .control_source_select_o(src_sel),
    .short_shutoff_o(shutoff), .stage_restart_o(restart), .battery_flag_valid_o(bvalid));
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_reg(input int r);
    logic [7:0] v;
    v = 8'hFF;
    for (int k = 0; k < 4; k++)
      if (r < 5 && 4 * r + k < 18) v[2*k +: 2] = code[4*r+k][1:0];
    if (r == 4) v[4] = batt;
    if (r == 5) v = cfg[7:0];
    return v;
  endfunction
  function automatic logic [17:0] exp_shut();
    logic [17:0] s;
    s = 18'h3FFFF;
    s[16] = cfg[2];
    s[17] = cfg[3];
    s[8] = cfg[4];
    s[9] = cfg[5];
    s[14] = cfg[6];
    s[15] = cfg[7];
    return s;
  endfunction
  // Read answer lands one edge after the request edge
  task automatic rd_chk(input int r);
    i_ldr_host_model.cmd(2'h0, r[7:0]);
    #1;
    chk("rd_valid", rd_valid, 1'b1);
    chk($sformatf("reg %0d", r), rd_data, exp_reg(r));
  endtask
  initial begin
    logic [63:0] f;
    cfg = $urandom(17126);
    cfg = 'hFF;
    for (int i = 0; i < 18; i++) code[i] = 3;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int r = 0; r < 8; r++) rd_chk(r);
    chk("src_sel", src_sel, 1'b1);
    chk("shutoff", shutoff, 18'h3FFFF);
    $display("reset test done");
    repeat (4) begin
      f[31:0] = $urandom;
      i_ldr_host_model.cmd(2'h1, f[7:0]);
      cfg = f[7:0] | 8'h01;
      rd_chk(5);
      chk("src_sel", src_sel, cfg[1]);
      chk("shutoff", shutoff, exp_shut());
      f = {$urandom, $urandom};
      @(posedge clk_i);
      faults <= f[35:0];
      batt <= f[40];
      for (int i = 0; i < 18; i++) code[i] = f[2*i +: 2];
      repeat (4) @(posedge clk_i);
      for (int r = 0; r < 5; r++) rd_chk(r);
      mask = '0;
      es = exp_shut();
      for (int i = 0; i < 18; i++) mask[i] = (code[i] == 2) && es[i];
      i_ldr_host_model.cmd(2'h2, 8'h00);
      #1;
      chk("restart", restart, mask);
      for (int r = 0; r < 5; r++) rd_chk(r);
      @(posedge clk_i);
      faults <= {36{1'b1}};
      vdd <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      chk("batt valid low", bvalid, 1'b0);
      i_ldr_host_model.cmd(2'h2, 8'h00);
      for (int i = 0; i < 18; i++) code[i] = 3;
      for (int r = 0; r < 5; r++) rd_chk(r);
      vdd <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("batt valid high", bvalid, 1'b1);
      $display("fault and config test done");
    end
    // A write taken while the clock enable is low must be lost
    @(posedge clk_i);
    ce <= 1'b0;
    i_ldr_host_model.cmd(2'h1, 8'h00);
    ce <= 1'b1;
    rd_chk(5);
    chk("src_sel frozen", src_sel, cfg[1]);
    $display("clock enable test done");
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    cfg = 'hFF;
    for (int r = 0; r < 6; r++) rd_chk(r);
    chk("src_sel", src_sel, 1'b1);
    chk("shutoff", shutoff, 18'h3FFFF);
    $display("second reset test done");
    end_of_test();
  end
endmodule // ldr_regs_bench

// >>> verilog/ldr_fault_field.sv
`timescale 1ns/100ps
// One stage's two-bit fault latch
module ldr_fault_field (
  input wire logic clk_i, // Clock
  input wire logic srst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic [1:0] fault_code_i, // Live fault code, synchronised
  input wire logic clear_i, // Clear-faults pulse
  output logic [1:0] code_o // Latched fault code
);
  logic [1:0] code_q;
  logic [1:0] code_d;
  logic latched_fault;

  assign latched_fault = (code_q != ldr_pkg::FC_NO_FAULT);
  // A clear takes the live code, so a fault still present is kept
  assign code_d = (clear_i || !latched_fault) ? fault_code_i : code_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      code_q <= ldr_pkg::FC_NO_FAULT;
    end else if (ce_i) begin
      code_q <= code_d;
    end
  end

  assign code_o = code_q;
endmodule // ldr_fault_field

// >>> verilog/ldr_regs.sv
`timescale 1ns/100ps
// Operation
// [R1] Five 8-bit diagnostic registers, read only, all ones after reset.
// [R2] Two bits per stage, four stages per register, lowest stage in bits 1-0.
// [R3] Codes: 11 no fault, 10 short to battery/overtemp, 01 open load, 00 ground.
// [R4] Fifth register bit 4 shows the live battery-sense pin level.
// [R5] Battery flag is meaningful only while the logic supply exceeds 4.5V.
// [R6] Bits 7-5 of the fifth diagnostic register always read as one.
// [R7] Read/write configuration register resets to FF; bit 0 reads one.
// [R8] Configuration bit 1: one selects parallel pins, zero the serial control bus.
// [R9] Shut-off selects: bits 2..7 map to stages 17,18,9,10,15,16.
// [R10] Unselected stage stays on during short; other stages always shut off.
// [R11] Clear command sets fields to ones unless their fault is still present.
// [R12] Clear command restarts a stage shut off for short to battery.
// [R13] Shut-off select of one means the stage shuts off on short.
module ldr_regs #(
  parameter int NUM_STAGES = ldr_pkg::NUM_STAGES
) (
  input wire logic clk_i, // 40 MHz clock
  input wire logic srst_i, // Sync reset, active high
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic rd_req_i, // Read command strobe from the serial front end
  input wire logic [2:0] rd_sel_i, // Register selected by the read command
  input wire logic wr_cfg_i, // Configuration write strobe
  input wire logic [7:0] wr_data_i, // Configuration write data
  input wire logic clear_faults_cmd_i, // Clear-faults command strobe
  input wire logic [2*NUM_STAGES-1:0] fault_code_bits_i, // Live codes, asynchronous
  input wire logic battery_sense_i, // Battery-sense comparator, asynchronous
  input wire logic vdd_ok_i, // Logic supply above 4.5V, asynchronous
  output logic [7:0] rd_data_o, // Read data
  output logic rd_valid_o, // Read data valid pulse
  output logic control_source_select_o, // 1 parallel pins, 0 serial bus
  output logic [NUM_STAGES-1:0] short_shutoff_o, // 1 shuts stage off on short
  output logic [NUM_STAGES-1:0] stage_restart_o, // Restart pulse after clear
  output logic battery_flag_valid_o // Battery flag qualified by supply
);
  localparam logic [2*NUM_STAGES-1:0] CODES_IDLE = '1;
  localparam int DIAG_BITS = 8 * ldr_pkg::NUM_DIAG_REGS;

  logic [2*NUM_STAGES-1:0] codes_sync;
  logic [2*NUM_STAGES-1:0] codes_latched;
  logic battery_sync;
  logic vdd_ok_sync;
  logic [DIAG_BITS-1:0] diag_flat;
  logic [7:0] diag5;
  logic [7:0] config_q;
  logic [7:0] config_d;
  logic [7:0] rd_word;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic src_sel_q;
  logic [NUM_STAGES-1:0] shutoff_q;
  logic [NUM_STAGES-1:0] shutoff_d;
  logic [NUM_STAGES-1:0] restart_q;
  logic [NUM_STAGES-1:0] restart_d;
  logic batt_valid_q;

  // Maps a stage index (0 based) to its shut-off select; fixed stages always shut off
  function automatic logic stage_shutoff(input int idx, input logic [7:0] cfg);
    logic r;
    r = 1'b1;
    case (idx)
      16: r = cfg[ldr_pkg::CFG_S17_BIT];
      17: r = cfg[ldr_pkg::CFG_S18_BIT];
      8: r = cfg[ldr_pkg::CFG_S9_BIT];
      9: r = cfg[ldr_pkg::CFG_S10_BIT];
      14: r = cfg[ldr_pkg::CFG_S15_BIT];
      15: r = cfg[ldr_pkg::CFG_S16_BIT];
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  ldr_sync2 #(
    .W(2 * NUM_STAGES),
    .RST_VAL(CODES_IDLE)
  ) u_code_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i(fault_code_bits_i),
    .q_o(codes_sync)
  );

  ldr_sync2 #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_pin_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i({battery_sense_i, vdd_ok_i}),
    .q_o({battery_sync, vdd_ok_sync})
  );

  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++) begin : g_stage
      ldr_fault_field u_field (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .fault_code_i(codes_sync[2*g+1:2*g]),
        .clear_i(clear_faults_cmd_i), // R11
        .code_o(codes_latched[2*g+1:2*g])
      );
      // Stage g sits in register g/4 at bits 2*(g%4)+1 : 2*(g%4)
      assign diag_flat[2*g+1:2*g] = codes_latched[2*g+1:2*g]; // R2 R3
      assign shutoff_d[g] = stage_shutoff(g, config_q); // R9 R10 R13
      // Only a stage latched on short to battery and set to shut off needs a restart
      assign restart_d[g] = clear_faults_cmd_i && shutoff_d[g]
        && (codes_latched[2*g+1:2*g] == ldr_pkg::FC_SHORT_BATT_OT); // R12
    end
  endgenerate

  // Fifth register: stages 17-18, live battery level, ones above
  assign diag5 = {ldr_pkg::DIAG5_UNUSED_VAL, battery_sync,
    codes_latched[2*NUM_STAGES-1:2*NUM_STAGES-4]}; // R4 R6
  assign diag_flat[DIAG_BITS-1:2*NUM_STAGES] = diag5[7:4];

  // Bit 0 is hard-wired high so software cannot clear it
  assign config_d = wr_cfg_i ? (wr_data_i | 8'h01) : config_q; // R7

  always_comb begin
    case (rd_sel_i)
      ldr_pkg::SEL_DIAG_1_4: rd_word = diag_flat[7:0]; // R1
      ldr_pkg::SEL_DIAG_5_8: rd_word = diag_flat[15:8];
      ldr_pkg::SEL_DIAG_9_12: rd_word = diag_flat[23:16];
      ldr_pkg::SEL_DIAG_13_16: rd_word = diag_flat[31:24];
      ldr_pkg::SEL_DIAG_17_18_BATT: rd_word = diag5;
      ldr_pkg::SEL_CONFIG: rd_word = config_q;
      default: rd_word = ldr_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      config_q <= ldr_pkg::CONFIG_RESET; // R7
      rd_data_q <= ldr_pkg::DIAG_RESET;
      rd_valid_q <= 1'b0;
      src_sel_q <= 1'b1;
      shutoff_q <= '1;
      restart_q <= '0;
      batt_valid_q <= 1'b0;
    end else if (ce_i) begin
      config_q <= config_d;
      rd_valid_q <= rd_req_i;
      if (rd_req_i) begin
        rd_data_q <= rd_word;
      end
      src_sel_q <= config_q[ldr_pkg::CFG_SRC_SEL_BIT]; // R8
      shutoff_q <= shutoff_d;
      restart_q <= restart_d;
      // Outside the supply window the flag still reads, but users must ignore it
      batt_valid_q <= vdd_ok_sync; // R5
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign control_source_select_o = src_sel_q;
  assign short_shutoff_o = shutoff_q;
  assign stage_restart_o = restart_q;
  assign battery_flag_valid_o = batt_valid_q;

  // Helper state for the checks
  logic [7:0] past_word;
  logic past_req;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      past_word <= 8'hFF;
      past_req <= 1'b0;
    end else if (ce_i) begin
      past_word <= rd_word;
      past_req <= rd_req_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  read_data_a: assert property (ce_i && rd_req_i |=> rd_valid_o && rd_data_o == past_word) // R1
    else $error("read data does not follow the selected register");
  diag_reset_a: assert property ($fell(srst_i) |-> codes_latched == CODES_IDLE) // R1
    else $error("diagnostic fields not all ones after reset");
  diag5_top_a: assert property (diag5[7:5] == 3'h7) // R6
    else $error("unused diagnostic bits not high");
  batt_live_a: assert property (ce_i ##1 ce_i ##1 ce_i |-> diag5[4] == $past(battery_sense_i, 2)) // R4
    else $error("battery flag is not the live pin level");
  cfg_bit0_a: assert property (config_q[0] == 1'b1) // R7
    else $error("configuration bit 0 reads low");
  cfg_write_a: assert property (ce_i && wr_cfg_i |=> config_q[7:1] == $past(wr_data_i[7:1])) // R7
    else $error("configuration write lost");
  src_sel_a: assert property (ce_i |=> control_source_select_o == $past(config_q[1])) // R8
    else $error("control source select does not follow configuration");
  shutoff_map_a: assert property (ce_i |=> short_shutoff_o[8] == $past(config_q[4])
    && short_shutoff_o[16] == $past(config_q[2]) && short_shutoff_o[0]) // R9
    else $error("shut-off select mapping wrong");
  clear_keep_a: assert property (ce_i && clear_faults_cmd_i |=>
    codes_latched == $past(codes_sync)) // R11
    else $error("clear does not take the live fault codes");
  // A frozen clock enable holds the pulse, so only a freshly loaded pulse is judged
  restart_a: assert property ($past(ce_i) && stage_restart_o[9] |-> $past(clear_faults_cmd_i)
    && $past(config_q[5])) // R12
    else $error("restart without clear or with shut-off disabled");

  valid_pulse_a: assert property (ce_i && !rd_req_i |=> !rd_valid_o) // R1
    else $error("read valid without a read command");

  unmapped_read_a: assert property (ce_i && rd_req_i && rd_sel_i > 3'h5 |=> rd_data_o == 8'hFF) // R1
    else $error("unmapped read select does not return ones");

  diag_read1_a: assert property (ce_i && rd_req_i && rd_sel_i == ldr_pkg::SEL_DIAG_1_4
    |=> rd_data_o[1:0] == $past(codes_latched[1:0])) // R2
    else $error("lowest stage not in bits 1-0 of the first register");

  diag_read5_a: assert property (ce_i && rd_req_i && rd_sel_i == ldr_pkg::SEL_DIAG_17_18_BATT
    |=> rd_data_o[3:0] == $past(codes_latched[35:32])) // R2
    else $error("stages 17 and 18 not in the fifth register");

  batt_read_a: assert property (ce_i && rd_req_i && rd_sel_i == ldr_pkg::SEL_DIAG_17_18_BATT
    |=> rd_data_o[4] == $past(battery_sync)) // R4
    else $error("battery flag missing from read data");

  diag5_read_a: assert property (ce_i && rd_req_i && rd_sel_i == ldr_pkg::SEL_DIAG_17_18_BATT
    |=> rd_data_o[7:5] == 3'h7) // R6
    else $error("unused read bits of the fifth register not high");

  cfg_read_a: assert property (ce_i && rd_req_i && rd_sel_i == ldr_pkg::SEL_CONFIG
    |=> rd_data_o == $past(config_q)) // R7
    else $error("configuration read returns wrong value");

  cfg_hold_a: assert property (ce_i && !wr_cfg_i |=> config_q == $past(config_q)) // R7
    else $error("configuration changed without a write");

  cfg_reset_a: assert property ($fell(srst_i) |-> config_q == ldr_pkg::CONFIG_RESET) // R7
    else $error("configuration not all ones after reset");

  // Reset leaves every selectable stage shutting off and no restart pending
  src_reset_a: assert property ($fell(srst_i) |-> control_source_select_o
    && short_shutoff_o == '1 && stage_restart_o == '0) // R13
    else $error("outputs not at their reset values");

  shutoff_fixed_a: assert property (short_shutoff_o[7:0] == 8'hFF
    && short_shutoff_o[13:10] == 4'hF) // R10
    else $error("non-selectable stage not set to shut off");

  shutoff_rest_a: assert property (ce_i |=> short_shutoff_o[9] == $past(config_q[5])
    && short_shutoff_o[14] == $past(config_q[6]) && short_shutoff_o[15] == $past(config_q[7])
    && short_shutoff_o[17] == $past(config_q[3])) // R9
    else $error("shut-off select mapping wrong for stages 10, 15, 16, 18");

  restart_fixed_a: assert property ($past(ce_i) && stage_restart_o[0]
    |-> $past(clear_faults_cmd_i) && $past(codes_latched[1:0]) == 2'h2) // R12
    else $error("restart of a fixed stage without a latched short");

  restart_none_a: assert property (ce_i && !clear_faults_cmd_i |=> stage_restart_o == '0) // R12
    else $error("restart pulse without a clear command");

  // A latched fault must survive until a clear, even if the live code recovers
  field_hold_a: assert property (ce_i && !clear_faults_cmd_i && codes_latched[1:0] != 2'h3
    |=> codes_latched[1:0] == $past(codes_latched[1:0])) // R11
    else $error("latched fault lost without a clear");

  batt_valid_a: assert property (ce_i |=> battery_flag_valid_o == $past(vdd_ok_sync)) // R5
    else $error("battery flag qualifier does not follow the supply");

  ce_freeze_a: assert property (!ce_i |=> config_q == $past(config_q)
    && codes_latched == $past(codes_latched) && short_shutoff_o == $past(short_shutoff_o)) // R7
    else $error("state changed while the clock enable was low");

endmodule // ldr_regs

// >>> verilog/ldr_sync2.sv
`timescale 1ns/100ps
// Two-stage synchroniser for pins from the analog side
module ldr_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i, // Clock
  input wire logic srst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic [W-1:0] d_i, // Asynchronous input
  output logic [W-1:0] q_o // Synchronised output
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // ldr_sync2
